// [test/odff_props.sv]
// odff_props.sv: port checks for the register; the bench binds it
`timescale 1ns/1ps
`default_nettype none
module odff_props(
  input wire logic ref_clk_in,
  input wire logic rst_b_in,
  input wire logic async_clear_n_in,
  input wire logic supply_ok_in,
  input wire logic [7:0] data_in,
  input wire logic [7:0] held_value_out,
  input wire logic [7:0] held_value_oe_out,
  input wire logic contents_valid_out
);
default clocking @(posedge ref_clk_in); endclocking
default disable iff (!rst_b_in);
wire c = async_clear_n_in;
wire p = supply_ok_in;
load_edge_a: assert property (c && p ##1 c |-> held_value_out == $past(data_in)) else $error("load");
clear_low_a: assert property (!c |-> held_value_out == 8'h00) else $error("clear");
power_on_a: assert property (p |=> held_value_oe_out == 8'hff && contents_valid_out) else $error("on");
power_off_a: assert property (!p |=> held_value_oe_out == 8'h00 && !contents_valid_out) else $error("off");
off_store_a: assert property (c && !p |=> held_value_out == 8'h00) else $error("unpowered edge kept data");
first_edge_a: assert property ($rose(rst_b_in) |-> !contents_valid_out) else $error("valid too early");
load_cov_c: cover property (c && p ##1 c);
clear_cov_c: cover property (!c);
off_cov_c: cover property (!p);
restart_cov_c: cover property ($rose(rst_b_in));
endmodule // odff_props
`default_nettype wire

// [test/odff_src.sv]
// odff_src.sv: upstream driver; launches just after the edge so inputs are steady at the next
`timescale 1ns/1ps
`default_nettype none
module odff_src(input wire logic clk_in,input wire logic [15:0] r_in,output logic [7:0] d_out=8'h0,
output logic c_out=1,p_out=1);
always @(posedge clk_in) {p_out,c_out,d_out}<={|r_in[15:12],|r_in[11:8],r_in[7:0]};
endmodule // odff_src
`default_nettype wire

// [test/testbench.sv]
// testbench.sv: corner cases, a random run with clear and power drops, and a reset in mid-run
// assumes: the upstream model launches its outputs by non-blocking assignment on the rising edge
`timescale 1ns/1ps
`default_nettype none
`define CHK(a,e) begin n_checks++; if ((a) !== (e)) begin miscompares++; $display("Error %0t output mismatch", $time); end end
module testbench;
logic clk = 1'b0;
logic rst_b = 1'b0;
logic c;
logic p;
logic [15:0] r = 16'hff00;
logic [15:0] lfsr_r = 16'h66aa;
logic [7:0] d;
logic [7:0] q;
logic [7:0] oe;
logic v;
logic [7:0] e = 8'h00;
logic [7:0] e_oe = 8'h00;
logic e_v = 1'b0;
int miscompares = 0;
int n_checks = 0;

function automatic logic [15:0] lfsr_next(input logic [15:0] s);
  return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
endfunction

function automatic logic [7:0] exp_word(input logic rb, input logic cl, input logic pw, input logic [7:0] dd);
  return (rb && cl && pw) ? dd : 8'h00;
endfunction

function automatic logic [7:0] exp_oe(input logic rb, input logic pw);
  return {8{rb && pw}};
endfunction

always #2.5 clk = ~clk;

odff_src odff_src_inst(.clk_in(clk), .r_in(r), .d_out(d), .c_out(c), .p_out(p));
odff_octal_reg odff_octal_reg_inst(.ref_clk_in(clk), .rst_b_in(rst_b), .async_clear_n_in(c), .supply_ok_in(p),
  .data_in(d), .held_value_out(q), .held_value_oe_out(oe), .contents_valid_out(v));

always @(posedge clk or negedge rst_b or negedge c)
begin
  e <= exp_word(rst_b, c, p, d);
end

always @(posedge clk or negedge rst_b)
begin
  e_oe <= exp_oe(rst_b, p);
  e_v <= rst_b && p;
end

always @(negedge clk)
begin
  `CHK(q, e)
  `CHK(oe, e_oe)
  `CHK(v, e_v)
end

task tally_and_finish;
  $display("checks %0d miscompares %0d", n_checks, miscompares);
  if (miscompares == 0 && n_checks > 0)
    $display("All tests passed");
  else
    $display("Some tests failed");
  $finish;
endtask

task automatic drive_case(input logic [15:0] pat);
  @(posedge clk);
  r <= pat;
endtask

// the tests take about 3030 cycles; 4000 leaves room without hiding a hang
initial
begin
  #(4000 * 5);
  miscompares++;
  tally_and_finish;
end

initial
begin
  repeat (3) @(posedge clk);
  rst_b <= 1'b1;
  drive_case(16'hffff);
  drive_case(16'hff00);
  drive_case(16'hf0a5);
  drive_case(16'hff5a);
  drive_case(16'h0f3c);
  drive_case(16'hffc3);
  drive_case(16'hffc3);
  $display("corner cases done");
  repeat (3000)
  begin
    @(posedge clk);
    lfsr_r = lfsr_next(lfsr_r);
    r <= lfsr_r;
  end
  $display("random done");
  @(posedge clk);
  rst_b <= 1'b0;
  repeat (2) @(posedge clk);
  rst_b <= 1'b1;
  repeat (20)
  begin
    @(posedge clk);
    lfsr_r = lfsr_next(lfsr_r);
    r <= lfsr_r;
  end
  $display("reset test done");
  tally_and_finish;
end
endmodule // testbench
bind odff_octal_reg odff_props odff_props_inst(.*);
`default_nettype wire

// [verilog/odff_octal_reg.v]
// odff_octal_reg.v: eight-bit register on one clock with a shared active-low clear
// assumes: data, clear and power-good are synchronous to ref_clk_in
// assumes: the driver holds data steady around each rising edge
// the supply input stands in for the real supply rail; low means unpowered
`timescale 1ns/1ps
`default_nettype none
`include "odff_regs.vh"

module odff_octal_reg (
  input wire ref_clk_in,
  input wire rst_b_in,
  input wire async_clear_n_in,
  input wire supply_ok_in,
  input wire [`ODFF_WIDTH-1:0] data_in,
  output reg [`ODFF_WIDTH-1:0] held_value_out,
  output reg [`ODFF_WIDTH-1:0] held_value_oe_out,
  output reg contents_valid_out
);

  // ----------------------------------------
  // helper functions
  // ----------------------------------------
  // fill a whole word from one bit, so every lane follows one decision
  function [`ODFF_WIDTH-1:0] word_fill;
    input fill_bit;
    begin
      word_fill = {`ODFF_WIDTH{fill_bit}};
    end
  endfunction

  // one lane's next value: a powered edge takes the data bit, an unpowered one the off bit
  function lane_next;
    input powered;
    input data_bit;
    input off_bit;
    begin
      case ({powered, data_bit})
        2'h3:
        begin
          lane_next = 1'h1;
        end
        2'h2:
        begin
          lane_next = 1'h0;
        end
        2'h1:
        begin
          lane_next = off_bit;
        end
        2'h0:
        begin
          lane_next = off_bit;
        end
        default:
        begin
          lane_next = off_bit;
        end
      endcase
    end
  endfunction

  // driver enable word: lanes drive only while the supply is good
  function [`ODFF_WIDTH-1:0] enable_word;
    input powered;
    begin
      if (powered)
      begin
        enable_word = word_fill(1'h1);
      end
      else
      begin
        enable_word = word_fill(1'h0);
      end
    end
  endfunction

  // ----------------------------------------
  // clear combine
  // ----------------------------------------
  // chip reset and the clear pin share one asynchronous path so all lanes clear together
  // limitation: a glitch on either input clears the word, just as on a real pin
  wire clear_b;
  assign clear_b = rst_b_in & async_clear_n_in;

  // ----------------------------------------
  // next stored value
  // ----------------------------------------
  // lanes are picked by index so no lane can take another lane's data
  wire [`ODFF_WIDTH-1:0] off_word;
  reg [`ODFF_WIDTH-1:0] held_value_nxt;
  integer lane_idx;

  assign off_word = `ODFF_OFF_VALUE;

  always @*
  begin
    held_value_nxt = word_fill(1'h0);
    for (lane_idx = 0; lane_idx < `ODFF_WIDTH; lane_idx = lane_idx + 1)
    begin
      held_value_nxt[lane_idx] = lane_next(supply_ok_in, data_in[lane_idx], off_word[lane_idx]);
    end
  end

  // ----------------------------------------
  // storage
  // ----------------------------------------
  // no power-up value is promised here; validity is tracked further down instead
  always @(posedge ref_clk_in or negedge clear_b)
  begin
    if (!clear_b)
    begin
      held_value_out <= `ODFF_CLEAR_VALUE;
    end
    else
    begin
      held_value_out <= held_value_nxt;
    end
  end
  // between rising edges only a low clear_b writes the word; otherwise the word holds

  // ----------------------------------------
  // supply state
  // ----------------------------------------
  // the word is only trusted after a powered edge; a supply drop voids it again
  // a real part would come up with random bits, so an invalid flag stands in for them
  localparam [0:0] PWR_DOWN = 1'h0;
  localparam [0:0] PWR_LIVE = 1'h1;

  reg pwr_state_r;
  reg pwr_state_nxt;

  always @*
  begin
    case (pwr_state_r)
      PWR_DOWN:
      begin
        if (supply_ok_in)
        begin
          pwr_state_nxt = PWR_LIVE;
        end
        else
        begin
          pwr_state_nxt = PWR_DOWN;
        end
      end
      PWR_LIVE:
      begin
        if (supply_ok_in)
        begin
          pwr_state_nxt = PWR_LIVE;
        end
        else
        begin
          pwr_state_nxt = PWR_DOWN;
        end
      end
      default:
      begin
        pwr_state_nxt = PWR_DOWN;
      end
    endcase
  end

  always @(posedge ref_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      pwr_state_r <= PWR_DOWN;
    end
    else
    begin
      pwr_state_r <= pwr_state_nxt;
    end
  end

  // ----------------------------------------
  // validity and output enable
  // ----------------------------------------
  // both outputs are registered from the next supply state, so they line up with the stored word
  reg contents_valid_nxt;
  reg [`ODFF_WIDTH-1:0] held_value_oe_nxt;

  always @*
  begin
    if (pwr_state_nxt == PWR_LIVE)
    begin
      contents_valid_nxt = 1'h1;
      held_value_oe_nxt = enable_word(1'h1);
    end
    else
    begin
      contents_valid_nxt = 1'h0;
      held_value_oe_nxt = enable_word(1'h0);
    end
  end

  always @(posedge ref_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      contents_valid_out <= 1'h0;
      held_value_oe_out <= {`ODFF_WIDTH{1'h0}};
    end
    else
    begin
      contents_valid_out <= contents_valid_nxt;
      held_value_oe_out <= held_value_oe_nxt;
    end
  end

endmodule // odff_octal_reg

`default_nettype wire

// [verilog/odff_regs.vh]
// odff_regs.vh: constants for the eight-bit clocked register with clear
// assumes: included by the register module only
`ifndef ODFF_REGS_VH
`define ODFF_REGS_VH

`define ODFF_WIDTH 8
`define ODFF_CLEAR_VALUE 8'h00
`define ODFF_OFF_VALUE 8'h00

`endif
